// *** design/uic_regs.vh ***
// register offsets, field positions, reset values and timing counts for the uart irq/fifo control
`ifndef UIC_REGS_VH
`define UIC_REGS_VH
`define UIC_OFF_DATA        8'h00
`define UIC_OFF_IER         8'h01
`define UIC_OFF_FCR_IIR     8'h02
`define UIC_OFF_LCR         8'h03
`define UIC_OFF_EVENTS      8'h04
`define UIC_OFF_STATUS      8'h05
`define UIC_ADDR_OF(i)      ((i) << 2)
`define UIC_IE_RDA          0
`define UIC_IE_THRE         1
`define UIC_IE_RLS          2
`define UIC_IE_MS           3
`define UIC_FC_EN           0
`define UIC_FC_RXCLR        1
`define UIC_FC_TXCLR        2
`define UIC_FC_DMA          3
`define UIC_FC_THR_HI       7
`define UIC_FC_THR_LO       6
`define UIC_LC_DIVISOR_ACCESS_SELECT         7
`define UIC_EV_RDREAD       0
`define UIC_EV_LSREAD       1
`define UIC_EV_MSREAD       2
`define UIC_EV_THRWR        3
`define UIC_IER_RST         4'h0
`define UIC_CID_RLS         3'b011
`define UIC_CID_RDA         3'b010
`define UIC_CID_TMO         3'b110
`define UIC_CID_THRE        3'b001
`define UIC_CID_MS          3'b000
`define UIC_TMO_CHARS       4
`define UIC_BITS_PER_CHAR   10
`endif

// *** design/uic_ctrl.v ***
// interrupt enable, fifo control and interrupt identification logic of a serial port
`timescale 1ns/1ns
`include "uic_regs.vh"
// Contract
// - all enables zero: no irq, no cause
// - status flags keep updating when disabled
// - bit3 enables modem status change interrupt
// - bit2 enables line error interrupt
// - bit1 enables transmit holding empty interrupt
// - bit0 enables data available and timeout
// - offset two: write fifo setup, read cause
// - threshold codes give 1,4,8,14 bytes
// - dma select bit ignored, no pins
// - tx flush bit empties tx fifo, self-clears
// - rx flush bit empties rx fifo, self-clears
// - enable bit on/off, off discards data
// - priority: line, data, tx empty, modem
// - cause frozen during cause register read
// - cause bits 7:6 mirror fifo enable
// - bits 3:1 encode top cause, timeout
// - bit0 low when pending, resets high
// - timeout after four idle char times
// - enables visible only when divisor access zero
module uic_ctrl #(
	parameter        CNT_W          = 5,
	parameter [15:0] BAUD_DIV       = 16'h0001,
	parameter        TMO_BIT_CYCLES = 16
)(
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write address
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// neighbouring uart state
	input  wire [CNT_W-1:0] rx_fifo_count,
	input  wire        rx_byte_in,
	input  wire        rx_byte_out,
	input  wire        rx_data_ready,
	input  wire        line_error,
	input  wire        modem_change,
	input  wire        tx_hold_empty,
	// fifo control to the data path, divisor access select and interrupt line
	output reg         fifos_on,
	output reg  [1:0]  rx_fifo_threshold,
	output reg         tx_fifo_flush,
	output reg         rx_fifo_flush,
	output reg         divisor_access_select,
	output reg         serial_irq
);
	localparam [31:0]      TMO_CYCLES = `UIC_TMO_CHARS * `UIC_BITS_PER_CHAR * TMO_BIT_CYCLES;
	localparam             TMO_W      = 24;
	// deliberate cut: 24 bits cover any sensible bit period
	localparam [TMO_W-1:0] TMO_LIMIT  = TMO_CYCLES[TMO_W-1:0];

	function [4:0] thr_bytes;
		input [1:0] code;
		begin
			case (code)
				2'b00:   thr_bytes = 5'h01;
				2'b01:   thr_bytes = 5'h04;
				2'b10:   thr_bytes = 5'h08;
				default: thr_bytes = 5'h0e;
			endcase
		end
	endfunction

	// true when a cause field carries the given code with the pending mark
	function cause_is;
		input [3:0] field;
		input [2:0] code;
		begin
			cause_is = (field == {code, 1'b0});
		end
	endfunction

	reg  [3:0]       irq_en;
	reg              thre_pend;
	reg              thre_prev;
	reg              tmo_pend;
	reg  [TMO_W-1:0] tmo_cnt;
	reg  [3:0]       cause_frz;
	reg              frz_valid;
	reg              aw_held;
	reg              w_held;
	reg  [7:0]       aw_q;
	reg  [31:0]      w_q;
	reg  [3:0]       ws_q;
	reg  [3:0]       ev_wr;
	reg  [7:0]       live_cause;
	reg              rda_cond;

	wire       aw_take = s_axi_awvalid & s_axi_awready;
	wire       w_take  = s_axi_wvalid & s_axi_wready;
	wire [7:0] wa      = aw_held ? aw_q : s_axi_awaddr;
	wire [31:0] wd     = w_held ? w_q : s_axi_wdata;
	wire [3:0] wst     = w_held ? ws_q : s_axi_wstrb;
	wire       wr_go   = (aw_held | aw_take) & (w_held | w_take) & ~s_axi_bvalid;
	wire       rd_go   = s_axi_arvalid & s_axi_arready;
	wire       wr_ok   = (wa[1:0] == 2'b00) && (wa[7:2] <= `UIC_OFF_STATUS);
	wire       wr_b0   = wr_go & wr_ok & wst[0];
	wire       wr_ier  = wr_b0 && (wa[7:2] == `UIC_OFF_IER) && !divisor_access_select;
	wire       wr_fcr  = wr_b0 && (wa[7:2] == `UIC_OFF_FCR_IIR);
	wire       wr_lcr  = wr_b0 && (wa[7:2] == `UIC_OFF_LCR);
	wire       wr_ev   = wr_b0 && (wa[7:2] == `UIC_OFF_EVENTS);
	wire       rd_iir  = rd_go && (s_axi_araddr == `UIC_ADDR_OF(`UIC_OFF_FCR_IIR));
	wire       thre_wr = wr_ev & wd[`UIC_EV_THRWR];
	wire       rdr_rd  = wr_ev & wd[`UIC_EV_RDREAD];

	// cause priority and encoding
	always @*
	begin
		live_cause = 8'h01;
		rda_cond = fifos_on ? (rx_fifo_count >= thr_bytes(rx_fifo_threshold)) : rx_data_ready;
		live_cause[7:6] = {2{fifos_on}};
		if (irq_en[`UIC_IE_RLS] && line_error)
			live_cause[3:0] = {`UIC_CID_RLS, 1'b0};
		else if (irq_en[`UIC_IE_RDA] && rda_cond)
			live_cause[3:0] = {`UIC_CID_RDA, 1'b0};
		else if (irq_en[`UIC_IE_RDA] && fifos_on && tmo_pend)
			live_cause[3:0] = {`UIC_CID_TMO, 1'b0};
		else if (irq_en[`UIC_IE_THRE] && thre_pend)
			live_cause[3:0] = {`UIC_CID_THRE, 1'b0};
		else if (irq_en[`UIC_IE_MS] && modem_change)
			live_cause[3:0] = {`UIC_CID_MS, 1'b0};
	end

	// bus handshake
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_q          <= 8'h00;
			w_q           <= 32'h0000_0000;
			ws_q          <= 4'h0;
		end
		else
		begin
			s_axi_awready <= ~aw_held & ~aw_take & ~s_axi_bvalid & ~wr_go;
			s_axi_wready  <= ~w_held & ~w_take & ~s_axi_bvalid & ~wr_go;
			if (aw_take)
			begin
				aw_q <= s_axi_awaddr;
			end
			if (w_take)
			begin
				w_q  <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			aw_held <= wr_go ? 1'b0 : (aw_held | aw_take);
			w_held  <= wr_go ? 1'b0 : (w_held | w_take);
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// read channel: ready never waits for arvalid, so a master that raises
	// arvalid first is not stuck; it drops from acceptance until the answer is taken
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= 2'b00;
			s_axi_rdata   <= 32'h0000_0000;
		end
		else
		begin
			s_axi_arready <= ~rd_go & ~s_axi_rvalid;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'b00;
				s_axi_rdata  <= 32'h0000_0000;
				case (s_axi_araddr)
					`UIC_ADDR_OF(`UIC_OFF_IER):
						s_axi_rdata[7:0] <= divisor_access_select ? 8'h00 : {4'h0, irq_en};
					`UIC_ADDR_OF(`UIC_OFF_FCR_IIR):
						s_axi_rdata[7:0] <= frz_valid ? {live_cause[7:4], cause_frz} : live_cause;
					`UIC_ADDR_OF(`UIC_OFF_LCR):
						s_axi_rdata[7:0] <= {divisor_access_select, 7'h00};
					`UIC_ADDR_OF(`UIC_OFF_EVENTS):
						s_axi_rdata[7:0] <= 8'h00;
					`UIC_ADDR_OF(`UIC_OFF_STATUS):
						s_axi_rdata[7:0] <= {3'b000, modem_change, line_error, tx_hold_empty,
							tmo_pend, serial_irq};
					default:
						s_axi_rresp <= 2'b10;
				endcase
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// interrupt enables and divisor access select
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_en                <= `UIC_IER_RST;
			divisor_access_select <= 1'b0;
		end
		else
		begin
			// enables ignored while the divisor sits at this index, so a divisor
			// write cannot silently change them
			if (wr_ier)
				irq_en <= wd[3:0];
			if (wr_lcr)
				divisor_access_select <= wd[`UIC_LC_DIVISOR_ACCESS_SELECT];
		end
	end

	// fifo control: write only, flush strobes last one cycle
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fifos_on              <= 1'b0;
			rx_fifo_threshold     <= 2'b00;
			tx_fifo_flush         <= 1'b0;
			rx_fifo_flush         <= 1'b0;
		end
		else
		begin
			// dma select bit is never looked at: no request pins exist
			tx_fifo_flush <= 1'b0;
			rx_fifo_flush <= 1'b0;
			if (wr_fcr)
			begin
				fifos_on <= wd[`UIC_FC_EN];
				if (wd[`UIC_FC_EN])
				begin
					rx_fifo_threshold <= wd[`UIC_FC_THR_HI:`UIC_FC_THR_LO];
					tx_fifo_flush     <= wd[`UIC_FC_TXCLR];
					rx_fifo_flush     <= wd[`UIC_FC_RXCLR];
				end
				else if (fifos_on)
				begin
					tx_fifo_flush <= 1'b1;
					rx_fifo_flush <= 1'b1;
				end
			end
		end
	end

	// transmitter-empty cause: set on the rising edge of the empty level; a set and
	// a clear in one cycle leave it set, so a fresh empty event is never lost
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			thre_pend <= 1'b0;
			thre_prev <= 1'b0;
		end
		else
		begin
			thre_prev <= tx_hold_empty;
			if (tx_hold_empty && !thre_prev)
				thre_pend <= 1'b1;
			else if (thre_wr
				|| (rd_iir && !frz_valid && cause_is(live_cause[3:0], `UIC_CID_THRE))
				|| (rd_iir && frz_valid && cause_is(cause_frz, `UIC_CID_THRE)))
				thre_pend <= 1'b0;
		end
	end

	// character timeout: counter restarts on any fifo traffic
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tmo_pend <= 1'b0;
			tmo_cnt  <= {TMO_W{1'b0}};
		end
		else
		begin
			if (!fifos_on || rx_fifo_count == {CNT_W{1'b0}} || rx_byte_in || rx_byte_out
				|| rx_fifo_flush)
				tmo_cnt <= {TMO_W{1'b0}};
			else if (tmo_cnt != TMO_LIMIT)
				tmo_cnt <= tmo_cnt + {{(TMO_W-1){1'b0}}, 1'b1};
			if (fifos_on && rx_fifo_count != {CNT_W{1'b0}} && tmo_cnt == TMO_LIMIT - 1'b1
				&& !rx_byte_in && !rx_byte_out)
				tmo_pend <= 1'b1;
			else if (rdr_rd || rx_byte_out || !fifos_on || rx_fifo_flush)
				tmo_pend <= 1'b0;
		end
	end

	// hold the cause seen at address acceptance until the answer is taken
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cause_frz <= 4'h1;
			frz_valid <= 1'b0;
		end
		else
		begin
			if (rd_iir)
			begin
				cause_frz <= live_cause[3:0];
				frz_valid <= 1'b1;
			end
			else if (s_axi_rvalid && s_axi_rready)
				frz_valid <= 1'b0;
		end
	end

	// interrupt line is registered so it never glitches while causes settle
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			serial_irq <= 1'b0;
		end
		else
		begin
			serial_irq <= ~live_cause[0];
		end
	end
endmodule

// *** testbench/uic_line_model.sv ***
// far-side model: receive fifo occupancy and byte strobes of the neighbouring uart
`timescale 1ns/1ns
module uic_line_model (
	// clock and reset
	input logic        aclk,
	input logic        aresetn,
	// bench stimulus and block control
	input logic        push,
	input logic        pop,
	input logic        fifos_on,
	input logic        rx_fifo_flush,
	// state seen by the block
	output logic [4:0] rx_fifo_count,
	output logic       rx_byte_in,
	output logic       rx_byte_out,
	output logic       rx_data_ready
);
	logic was_on;
	assign rx_data_ready = (rx_fifo_count != 5'h00);
	always @(posedge aclk)
	begin
		was_on <= aresetn && fifos_on;
		rx_byte_in <= aresetn && push;
		rx_byte_out <= aresetn && pop && rx_data_ready;
		if (!aresetn || rx_fifo_flush || (was_on && !fifos_on))
			rx_fifo_count <= 5'h00;
		else
			rx_fifo_count <= rx_fifo_count + push - (pop && rx_data_ready);
	end
endmodule

// *** testbench/uic_ctrl_properties.sv ***
// concurrent checks on the uart interrupt and fifo control ports
`timescale 1ns/1ns
module uic_chk (
	// clock, reset and bus
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic [7:0]  s_axi_araddr,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	// fifo control
	input logic        fifos_on,
	input logic        tx_fifo_flush,
	input logic        rx_fifo_flush
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	sequence s_iir; s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h08; endsequence
	property p_wr_rsp; s_wr |=> s_axi_bvalid; endproperty
	a_wr_rsp: assert property (p_wr_rsp) else $error("no write response");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped");
	property p_rd_rsp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_rsp: assert property (p_rd_rsp) else $error("no read response");
	property p_freeze; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_freeze: assert property (p_freeze) else $error("cause changed in read");
	property p_fbits; s_iir |=> s_axi_rdata[7:4] == {$past(fifos_on), $past(fifos_on), 2'b00}; endproperty
	a_fbits: assert property (p_fbits) else $error("fifo flag bits wrong");
	property p_bit3; s_iir ##0 !fifos_on |=> !s_axi_rdata[3]; endproperty
	a_bit3: assert property (p_bit3) else $error("bit3 set in byte mode");
	property p_txf; tx_fifo_flush |=> !tx_fifo_flush; endproperty
	a_txf: assert property (p_txf) else $error("tx flush not one cycle");
	property p_rxf; rx_fifo_flush |=> !rx_fifo_flush; endproperty
	a_rxf: assert property (p_rxf) else $error("rx flush not one cycle");
	property p_fen; rx_fifo_flush |-> fifos_on || $past(fifos_on); endproperty
	a_fen: assert property (p_fen) else $error("flush with fifos off");
endmodule
bind uic_ctrl uic_chk u_chk (.*);

// *** testbench/tb_uart_irq_fifo_control.sv ***
// bench for the uart interrupt and fifo control block over axi4-lite
`timescale 1ns/1ns
module tb_uart_irq_fifo_control;
	logic aclk = 0, aresetn = 0, push = 0, pop = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_rvalid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic [1:0] s_axi_bresp, s_axi_rresp, rx_fifo_threshold, rrsp;
	logic rx_byte_in, rx_byte_out, rx_data_ready, line_error = 0, modem_change = 0;
	logic tx_hold_empty = 0, fifos_on, tx_fifo_flush, rx_fifo_flush;
	logic divisor_access_select, serial_irq;
	logic [4:0] rx_fifo_count;
	int miscompares = 0, n_tests = 0, cyc = 0, n_rxf = 0, n_txf = 0;
	uic_ctrl #(.TMO_BIT_CYCLES(1)) u_dut (.*);
	uic_line_model u_line (.*);
	always #25 aclk = ~aclk;
	always @(posedge aclk)
	begin
		n_rxf <= n_rxf + rx_fifo_flush;
		n_txf <= n_txf + tx_fifo_flush;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			miscompares++;
			print_verdict;
		end
	end
	task print_verdict;
		if (miscompares == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// rready is raised only once rvalid is seen, so every read also tests the freeze
	task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) s_axi_rready <= 1'b1;
		end
		while (!(s_axi_bvalid && s_axi_bready) && !(s_axi_rvalid && s_axi_rready));
		rdat = s_axi_rdata;
		rrsp = w ? s_axi_bresp : s_axi_rresp;
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask
	task rc(input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk("rdata", {24'h00_0000, e}, rdat);
	endtask
	task pulse;
		@(posedge aclk) push <= 1'b1;
		@(posedge aclk) push <= 1'b0;
	endtask
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk) line_error <= 1'b1;
		rc(8'h08, 8'h01);
		rc(8'h04, 8'h00);
		rc(8'h14, 8'h08);
		chk("irq", 0, serial_irq);
		acc(1'b1, 8'h04, 8'h0f);
		chk("bresp", 0, rrsp);
		modem_change <= 1'b1;
		rc(8'h08, 8'h06);
		chk("irq", 1, serial_irq);
		line_error <= 1'b0;
		rc(8'h08, 8'h00);
		tx_hold_empty <= 1'b1;
		rc(8'h08, 8'h02);
		rc(8'h08, 8'h00);
		@(posedge aclk) tx_hold_empty <= 1'b0;
		@(posedge aclk) tx_hold_empty <= 1'b1;
		acc(1'b1, 8'h10, 8'h08);
		rc(8'h08, 8'h00);
		modem_change <= 1'b0;
		acc(1'b1, 8'h0c, 8'h80);
		chk("divisor_access_select", 1, divisor_access_select);
		rc(8'h04, 8'h00);
		acc(1'b1, 8'h04, 8'h00);
		acc(1'b1, 8'h0c, 8'h00);
		rc(8'h04, 8'h0f);
		for (int i = 0; i < 4; i++)
		begin
			acc(1'b1, 8'h08, {i[1:0], 6'h09});
			chk("thr", i, rx_fifo_threshold);
		end
		rc(8'h08, 8'hc1);
		pulse;
		repeat (60) @(posedge aclk);
		rc(8'h08, 8'hcc);
		acc(1'b1, 8'h10, 8'h01);
		rc(8'h08, 8'hc1);
		acc(1'b1, 8'h08, 8'hc3);
		acc(1'b1, 8'h08, 8'hc5);
		@(posedge aclk);
		chk("rxcnt", 0, rx_fifo_count);
		chk("flush", 2, n_rxf + n_txf);
		acc(1'b1, 8'h08, 8'h01);
		pulse;
		rc(8'h08, 8'hc4);
		@(posedge aclk) pop <= 1'b1;
		@(posedge aclk) pop <= 1'b0;
		rc(8'h08, 8'hc1);
		acc(1'b1, 8'h08, 8'hc6);
		rc(8'h08, 8'h01);
		chk("fifo", 0, {fifos_on, rx_fifo_threshold, rx_fifo_count});
		rc(8'h18, 8'h00);
		chk("rresp", 2, rrsp);
		acc(1'b1, 8'h18, 8'hff);
		chk("bresp", 2, rrsp);
		print_verdict;
	end
endmodule
